// >>> bench/dsr_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none

// serves the lowest pending line after i_lat idle cycles, one per pulse
module dsr_ctrl_model
(
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // pacing
  input  wire logic       i_en,
  input  wire logic [7:0] i_lat,
  // requests in, service start out
  input  wire logic [7:0] i_req,
  output var  logic [7:0] o_start = 8'h00
);
  logic [7:0] wait_r = 8'h00;

  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !i_en || i_req == 8'h00)
    begin
      wait_r  <= 8'h00;
      o_start <= 8'h00;
    end
    else if (wait_r < i_lat)
    begin
      wait_r  <= wait_r + 8'h01;
      o_start <= 8'h00;
    end
    else
    begin
      wait_r  <= 8'h00;
      o_start <= i_req & (~i_req + 8'h01);
    end
  end
endmodule

`default_nettype wire

// >>> bench/dsr_router_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module dsr_router_monitor
#(
  parameter int CH = 8
)
(
  // clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_sys_rst,
  // register port
  input  wire logic [7:0]    i_reg_addr,
  input  wire logic [31:0]   i_reg_wdata,
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  input  wire logic [31:0]   o_reg_rdata,
  // request side
  input  wire logic [CH-1:0] i_ext_request_in_n,
  input  wire logic [CH-1:0] i_xfer_start,
  input  wire logic [CH-1:0] o_ctrl_request_out,
  input  wire logic          o_bus_lock
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  logic [31:0]   ctrl_r;
  logic [CH-1:0] byp_r;
  logic [CH-1:0] iom_r;
  logic [CH-1:0] pin_d_r;
  logic [3:0]    wr_age_r;
  logic [3:0]    pin_age_r;
  wire  logic [CH-1:0] svc_w = i_xfer_start & iom_r & ~byp_r;

  // shadow of the writable words, so checks need no internal probes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      ctrl_r <= 32'h0;
      byp_r  <= '0;
      iom_r  <= '0;
    end
    else if (i_reg_wr && i_reg_addr == dsr_pkg::DSR_OFF_CTRL)
      ctrl_r <= i_reg_wdata;
    else if (i_reg_wr && i_reg_addr == dsr_pkg::DSR_OFF_BYPASS)
      byp_r <= i_reg_wdata[CH-1:0];
    else if (i_reg_wr && i_reg_addr == dsr_pkg::DSR_OFF_IOMAP)
      iom_r <= i_reg_wdata[CH-1:0];
  end

  always_ff @(posedge i_clk_sys)
  begin
    pin_d_r <= i_ext_request_in_n;
    if (i_sys_rst || i_reg_wr)
      wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hf)
      wr_age_r <= wr_age_r + 4'h1;
    if (i_sys_rst || i_ext_request_in_n != pin_d_r)
      pin_age_r <= 4'h0;
    else if (pin_age_r != 4'hf)
      pin_age_r <= pin_age_r + 4'h1;
  end

  rst_quiet_a: assert property ($past(i_sys_rst) |->
    o_ctrl_request_out == '0 && !o_bus_lock && o_reg_rdata == 32'h0)
    else $error("outputs not quiet after reset");
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  unmapped_rd_a: assert property
    ($past(i_reg_rd && i_reg_addr[7:4] != 4'h0) |-> o_reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  status_view_a: assert property
    ($past(i_reg_rd && i_reg_addr == dsr_pkg::DSR_OFF_STATUS) |->
     o_reg_rdata[CH-1:0] == $past(o_ctrl_request_out) &&
     o_reg_rdata[16] == $past(o_bus_lock))
    else $error("status word wrong");
  lock_cmd_a: assert property
    (wr_age_r > 4'h0 |-> o_bus_lock == (ctrl_r[1:0] != 2'h0))
    else $error("bus lock wrong");
  bypass_follow_a: assert property
    (wr_age_r > 4'h1 && pin_age_r > 4'h3 && $stable(i_ext_request_in_n)
     |-> (o_ctrl_request_out & byp_r) == (~i_ext_request_in_n & byp_r))
    else $error("bypass line not following pin");
  service_clr_a: assert property
    (ctrl_r[1:0] == 2'h0 && wr_age_r > 4'h2 && svc_w != '0 &&
     pin_age_r > 4'h5 && $stable(i_ext_request_in_n)
     |-> ##2 (o_ctrl_request_out & $past(svc_w, 2)) == '0)
    else $error("serviced line not dropped");
  cmd_set_a: assert property
    (ctrl_r[1:0] == 2'h1 && !ctrl_r[10] && wr_age_r > 4'h1 &&
     !byp_r[ctrl_r[9:8]] |-> o_ctrl_request_out[ctrl_r[9:8]])
    else $error("software set missing");
  cmd_clr_a: assert property
    (ctrl_r[1:0] == 2'h2 && !ctrl_r[10] && wr_age_r > 4'h1 &&
     pin_age_r > 4'h5 && !byp_r[ctrl_r[9:8]]
     |-> !o_ctrl_request_out[ctrl_r[9:8]])
    else $error("software clear missing");
endmodule

bind dsr_router dsr_router_monitor #(.CH(CH)) u_mon
(
  .i_clk_sys          (i_clk_sys),
  .i_sys_rst          (i_sys_rst),
  .i_reg_addr         (i_reg_addr),
  .i_reg_wdata        (i_reg_wdata),
  .i_reg_wr           (i_reg_wr),
  .i_reg_rd           (i_reg_rd),
  .o_reg_rdata        (o_reg_rdata),
  .i_ext_request_in_n (i_ext_request_in_n),
  .i_xfer_start       (i_xfer_start),
  .o_ctrl_request_out (o_ctrl_request_out),
  .o_bus_lock         (o_bus_lock)
);

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        i_clk_sys = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  pin_n = 8'hff;
  logic [7:0]  xfer;
  logic [7:0]  req;
  logic        lock;
  logic        ctl_en = 1'b0;
  logic [7:0]  ctl_lat = 8'h1e;
  logic [7:0]  byp;
  logic [31:0] tab [8] = '{32'h100, 32'h300, 32'h7710, 32'h10c,
                           32'h30c, 32'h71c, 32'h171c, 32'h771c};
  integer      seed = 38140;
  integer      miscompares = 0;
  integer      checked = 0;
  integer      i;
  integer      k;
  integer      r;

  always #5 i_clk_sys = ~i_clk_sys;

  dsr_router #(.CH(8)) DUT
  (
    .i_clk_sys          (i_clk_sys),
    .i_sys_rst          (i_sys_rst),
    .i_reg_addr         (addr),
    .i_reg_wdata        (wdata),
    .i_reg_wr           (wr),
    .i_reg_rd           (rd),
    .o_reg_rdata        (rdata),
    .i_ext_request_in_n (pin_n),
    .i_xfer_start       (xfer),
    .o_ctrl_request_out (req),
    .o_bus_lock         (lock)
  );

  dsr_ctrl_model u_ctl
  (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_en      (ctl_en),
    .i_lat     (ctl_lat),
    .i_req     (req),
    .o_start   (xfer)
  );

  // lines with local index up to the limit; b only when linked
  function automatic logic [7:0] par_mask(input logic [31:0] c);
    logic [1:0] a;
    logic [1:0] b;
    a = c[10] ? 2'h3 : c[9:8];
    b = c[14] ? 2'h3 : c[13:12];
    return {c[4] ? 4'hf >> (2'h3 - b) : 4'h0, 4'hf >> (2'h3 - a)};
  endfunction

  function automatic logic [7:0] cyc_line(input logic [31:0] c, input int n);
    int m;
    m = c[4] ? 8 : int'(c[9:8]) + 1;
    return 8'h01 << (n % m);
  endfunction

  task automatic tick(input int c);
    repeat (c) @(posedge i_clk_sys);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked = checked + 1;
    if (seen !== want)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] want);
    @(posedge i_clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    #1 chk(rdata, want);
  endtask

  task automatic pulse(input int ch, input int hold, input logic [7:0] held,
                       input int settle, input logic [7:0] after);
    @(posedge i_clk_sys);
    pin_n[ch] <= 1'b0;
    tick(hold);
    #1 chk(32'(req), 32'(held));
    @(posedge i_clk_sys);
    pin_n[ch] <= 1'b1;
    tick(settle);
    #1 chk(32'(req), 32'(after));
  endtask

  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    tick(12);
    i_sys_rst <= 1'b0;
    wreg(8'h10, 32'hffffffff);
    rreg(dsr_pkg::DSR_OFF_CTRL, 32'h0);
    rreg(dsr_pkg::DSR_OFF_BYPASS, 32'h0);
    rreg(dsr_pkg::DSR_OFF_STATUS, 32'h0);
    rreg(8'h10, 32'h0);
    $display("test reset done");
    r = {$random(seed)} % 8;
    for (i = 0; i < 8; i++)
    begin
      k = (i + r) % 8;
      pulse(k, 8, 8'h01 << k, 8, 8'h00);
    end
    $display("test normal done");
    byp = 8'($random(seed));
    wreg(dsr_pkg::DSR_OFF_BYPASS, {24'h0, byp});
    repeat (4)
    begin
      @(posedge i_clk_sys);
      pin_n <= 8'($random(seed));
      tick(6);
      #1 chk(32'(req & byp), 32'(~pin_n & byp));
    end
    @(posedge i_clk_sys);
    pin_n <= 8'hff;
    wreg(dsr_pkg::DSR_OFF_BYPASS, 32'h0);
    tick(8);
    #1 chk(32'(req), 32'h0);
    $display("test bypass done");
    for (i = 0; i < 8; i++)
    begin
      wreg(dsr_pkg::DSR_OFF_CTRL, 32'h3);
      rreg(dsr_pkg::DSR_OFF_STATUS, 32'h10000);
      wreg(dsr_pkg::DSR_OFF_CTRL, tab[i]);
      wreg(dsr_pkg::DSR_OFF_IOMAP, {24'h0, {8{tab[i][2]}}});
      ctl_en  <= tab[i][2];
      ctl_lat <= 8'h1e;
      if (tab[i][2])
        pulse(0, 8, par_mask(tab[i]), 300, 8'h00);
      else
        for (k = 0; k < 9; k++)
          pulse(0, 8, cyc_line(tab[i], k), 8, 8'h00);
    end
    $display("test scan done");
    wreg(dsr_pkg::DSR_OFF_CTRL, 32'h0);
    ctl_lat <= 8'h03;
    for (i = 0; i < 8; i++)
      pulse(i, 20, 8'h00, 8, 8'h00);
    $display("test service done");
    ctl_en <= 1'b0;
    // i/o mapped, no service: withdrawal comes first and drops the line
    pulse(2, 8, 8'h04, 8, 8'h00);
    wreg(dsr_pkg::DSR_OFF_IOMAP, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      wreg(dsr_pkg::DSR_OFF_CTRL, 32'h1 | (i << 8) | ((i + 4) << 12));
      tick(3);
      #1 chk(32'(req), 32'h11 << i);
      chk(32'(lock), 32'h1);
      wreg(dsr_pkg::DSR_OFF_CTRL, 32'h2 | (i << 8) | ((i + 4) << 12));
      tick(3);
      #1 chk(32'(req), 32'h0);
    end
    wreg(dsr_pkg::DSR_OFF_CTRL, 32'h0);
    tick(2);
    #1 chk(32'(lock), 32'h0);
    $display("test command done");
    tally_and_finish();
  end

  initial
  begin
    #200000;
    miscompares = miscompares + 1;
    tally_and_finish();
  end
endmodule

`default_nettype wire

// >>> design/dsr_pkg.sv
package dsr_pkg;

  // channel counts
  localparam int DSR_CH      = 8;
  localparam int DSR_HALF    = 4;
  localparam int DSR_WRAP_W  = 3;

  // register bus
  localparam int DSR_ADDR_W  = 8;
  localparam int DSR_DATA_W  = 32;

  // word offsets (byte addresses)
  localparam logic [7:0] DSR_OFF_CTRL   = 8'h00;
  localparam logic [7:0] DSR_OFF_BYPASS = 8'h04;
  localparam logic [7:0] DSR_OFF_IOMAP  = 8'h08;
  localparam logic [7:0] DSR_OFF_STATUS = 8'h0c;

  // control word field positions
  localparam int DSR_CTRL_CMD_LSB    = 0;
  localparam int DSR_CTRL_STYLE_A    = 2;
  localparam int DSR_CTRL_STYLE_B    = 3;
  localparam int DSR_CTRL_LINK       = 4;
  localparam int DSR_CTRL_WRAP_A_LSB = 8;
  localparam int DSR_CTRL_WRAP_B_LSB = 12;

  // status word field positions
  localparam int DSR_STAT_REQ_LSB    = 0;
  localparam int DSR_STAT_CNT_A_LSB  = 8;
  localparam int DSR_STAT_CNT_B_LSB  = 12;
  localparam int DSR_STAT_LOCK       = 16;

  // reset values
  localparam logic [1:0] DSR_RST_CMD    = 2'h0;
  localparam logic [2:0] DSR_RST_WRAP   = 3'h0;
  localparam logic [7:0] DSR_RST_BYPASS = 8'h00;
  localparam logic [7:0] DSR_RST_IOMAP  = 8'h00;
  localparam logic [7:0] DSR_RST_PIN    = 8'hff;

  // circuit bases
  localparam logic [2:0] DSR_BASE_A     = 3'h0;
  localparam logic [2:0] DSR_BASE_B     = 3'h4;

  // channels whose own input sets their own line directly
  localparam logic [7:0] DSR_OWN_SET_MASK = 8'hee;

  typedef enum logic [1:0]
  {
    DSR_CMD_RUN     = 2'b00,
    DSR_CMD_SET     = 2'b01,
    DSR_CMD_CLR     = 2'b10,
    DSR_CMD_CNT_CLR = 2'b11
  } dsr_cmd_t;

endpackage

// >>> design/dsr_router.sv
// Functional notes
// - circuit A serves channels 3..0, circuit B serves channels 7..4.
// - each circuit has own 3-bit limit and style; one shared command.
// - bypass bit set drives request n straight from inverted input n.
// - bypass bit clear routes request n through the scan circuit.
// - input n asserts request n; inputs 0 and 4 follow the scan mode.
// - style 0, memory-mapped: request drops only when input withdrawn.
// - style 0, I/O-mapped: drops on withdrawal or transfer, first wins.
// - style 1, I/O-mapped: drops only on transfer; memory-mapped illegal.
// - I/O-mapped request drops as soon as servicing begins.
// - cyclic style steps to next line on each scan-input assertion.
// - parallel style asserts all lines up to limit at once.
// - command 00 and limits 000 give one-to-one routing.
// - cyclic limits 001, 011, linked 111 cycle over 1..0, 3..0, 7..0.
// - parallel limits drive 1..0, 3..0, or linked 4..0, 5..0, 7..0.
// - commands 01 and 10 set or clear the line named by limit.
// - command 11 with limit 000 clears that circuit's counter.
// - circuit B runs from input 4, or from input 0 when linked.
// - nonzero command keeps the controller locked off the bus.
`timescale 1ns/100ps
`default_nettype none

module dsr_router
#(
  parameter int CH = dsr_pkg::DSR_CH
)
(
  // clock and reset
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_sys_rst,
  // register port
  input  wire logic [dsr_pkg::DSR_ADDR_W-1:0] i_reg_addr,
  input  wire logic [dsr_pkg::DSR_DATA_W-1:0] i_reg_wdata,
  input  wire logic                           i_reg_wr,
  input  wire logic                           i_reg_rd,
  output var  logic [dsr_pkg::DSR_DATA_W-1:0] o_reg_rdata,
  // requesting devices, active low pins
  input  wire logic [CH-1:0]                  i_ext_request_in_n,
  // dma controller side
  input  wire logic [CH-1:0]                  i_xfer_start,
  output var  logic [CH-1:0]                  o_ctrl_request_out,
  output var  logic                           o_bus_lock
);

  // control registers
  logic [1:0]    cmd_r;
  logic          scan_a_style_r;
  logic          scan_b_style_r;
  logic          link_scan_halves_r;
  logic [2:0]    scan_a_wrap_value_r;
  logic [2:0]    scan_b_wrap_value_r;
  logic [CH-1:0] bypass_r;
  logic [CH-1:0] io_mapped_r;

  // request path
  logic [CH-1:0] pin_lvl;
  logic [CH-1:0] req;
  logic [CH-1:0] req_prev_r;
  logic [CH-1:0] req_rise;
  logic [CH-1:0] latch_r;
  logic [CH-1:0] latch_nxt;
  logic [CH-1:0] scan_src_r;
  logic [CH-1:0] cmd_hold_r;
  logic [CH-1:0] line_style;
  logic [CH-1:0] src_lvl;
  logic [CH-1:0] set_vec;
  logic [CH-1:0] clr_vec;
  logic [CH-1:0] hit_vec;
  logic [CH-1:0] cmd_set_vec;
  logic [CH-1:0] cmd_clr_vec;
  logic [CH-1:0] withdraw;
  logic [CH-1:0] serviced;

  // scan circuit wiring
  logic          trig_a;
  logic          trig_b;
  logic          src_a_lvl;
  logic          src_b_lvl;
  logic [2:0]    cnt_base_b;
  logic [3:0]    hit_a;
  logic [3:0]    hit_b;
  logic [3:0]    cset_a;
  logic [3:0]    cset_b;
  logic [3:0]    cclr_a;
  logic [3:0]    cclr_b;
  logic [2:0]    cnt_a;
  logic [2:0]    cnt_b;

  logic [dsr_pkg::DSR_DATA_W-1:0] rd_mux;

  // register writes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      cmd_r               <= dsr_pkg::DSR_RST_CMD;
      scan_a_style_r      <= 1'b0;
      scan_b_style_r      <= 1'b0;
      link_scan_halves_r  <= 1'b0;
      scan_a_wrap_value_r <= dsr_pkg::DSR_RST_WRAP;
      scan_b_wrap_value_r <= dsr_pkg::DSR_RST_WRAP;
    end
    else if (i_reg_wr && (i_reg_addr == dsr_pkg::DSR_OFF_CTRL))
    begin
      cmd_r <= i_reg_wdata[dsr_pkg::DSR_CTRL_CMD_LSB +: 2];
      scan_a_style_r <= i_reg_wdata[dsr_pkg::DSR_CTRL_STYLE_A];
      scan_b_style_r <= i_reg_wdata[dsr_pkg::DSR_CTRL_STYLE_B];
      link_scan_halves_r <= i_reg_wdata[dsr_pkg::DSR_CTRL_LINK];
      scan_a_wrap_value_r <= i_reg_wdata[dsr_pkg::DSR_CTRL_WRAP_A_LSB +: 3];
      scan_b_wrap_value_r <= i_reg_wdata[dsr_pkg::DSR_CTRL_WRAP_B_LSB +: 3];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      bypass_r <= dsr_pkg::DSR_RST_BYPASS;
    else if (i_reg_wr && (i_reg_addr == dsr_pkg::DSR_OFF_BYPASS))
      bypass_r <= i_reg_wdata[CH-1:0];
  end

  // requester mapping: 1 = I/O mapped, 0 = memory mapped
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      io_mapped_r <= dsr_pkg::DSR_RST_IOMAP;
    else if (i_reg_wr && (i_reg_addr == dsr_pkg::DSR_OFF_IOMAP))
      io_mapped_r <= i_reg_wdata[CH-1:0];
  end

  // register reads, data valid only in the following cycle
  always_comb
  begin
    rd_mux = '0;
    case (i_reg_addr)
      dsr_pkg::DSR_OFF_CTRL:
      begin
        rd_mux[dsr_pkg::DSR_CTRL_CMD_LSB +: 2] = cmd_r;
        rd_mux[dsr_pkg::DSR_CTRL_STYLE_A] = scan_a_style_r;
        rd_mux[dsr_pkg::DSR_CTRL_STYLE_B] = scan_b_style_r;
        rd_mux[dsr_pkg::DSR_CTRL_LINK] = link_scan_halves_r;
        rd_mux[dsr_pkg::DSR_CTRL_WRAP_A_LSB +: 3] = scan_a_wrap_value_r;
        rd_mux[dsr_pkg::DSR_CTRL_WRAP_B_LSB +: 3] = scan_b_wrap_value_r;
      end
      dsr_pkg::DSR_OFF_BYPASS:
        rd_mux[CH-1:0] = bypass_r;
      dsr_pkg::DSR_OFF_IOMAP:
        rd_mux[CH-1:0] = io_mapped_r;
      dsr_pkg::DSR_OFF_STATUS:
      begin
        rd_mux[dsr_pkg::DSR_STAT_REQ_LSB +: CH] = o_ctrl_request_out;
        rd_mux[dsr_pkg::DSR_STAT_CNT_A_LSB +: 3] = cnt_a;
        rd_mux[dsr_pkg::DSR_STAT_CNT_B_LSB +: 3] = cnt_b;
        rd_mux[dsr_pkg::DSR_STAT_LOCK] = o_bus_lock;
      end
      default:
        rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_reg_rdata <= '0;
    else
      o_reg_rdata <= i_reg_rd ? rd_mux : '0;
  end

  // pins come from outside the clock domain
  dsr_sync3
  #(
    .W       (CH),
    .RST_VAL (dsr_pkg::DSR_RST_PIN)
  )
  u_pin_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_ext_request_in_n),
    .o_level   (pin_lvl)
  );

  assign req = ~pin_lvl;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      req_prev_r <= '0;
    else
      req_prev_r <= req;
  end

  assign req_rise = req & ~req_prev_r;

  // linking feeds input 0 into circuit B in place of input 4
  assign trig_a     = req_rise[0];
  assign trig_b     = link_scan_halves_r ? req_rise[0]
                                         : req_rise[4];
  assign src_a_lvl  = req[0];
  assign src_b_lvl  = link_scan_halves_r ? req[0] : req[4];
  assign cnt_base_b = link_scan_halves_r ? dsr_pkg::DSR_BASE_B
                                         : dsr_pkg::DSR_BASE_A;

  dsr_scan
  #(
    .CH_BASE (dsr_pkg::DSR_BASE_A)
  )
  u_scan_a
  (
    .i_clk_sys  (i_clk_sys),
    .i_sys_rst  (i_sys_rst),
    .i_cmd      (cmd_r),
    .i_style    (scan_a_style_r),
    .i_wrap     (scan_a_wrap_value_r),
    .i_cnt_base (dsr_pkg::DSR_BASE_A),
    .i_trig     (trig_a),
    .o_hit      (hit_a),
    .o_cmd_set  (cset_a),
    .o_cmd_clr  (cclr_a),
    .o_cnt      (cnt_a)
  );

  dsr_scan
  #(
    .CH_BASE (dsr_pkg::DSR_BASE_B)
  )
  u_scan_b
  (
    .i_clk_sys  (i_clk_sys),
    .i_sys_rst  (i_sys_rst),
    .i_cmd      (cmd_r),
    .i_style    (scan_b_style_r),
    .i_wrap     (scan_b_wrap_value_r),
    .i_cnt_base (cnt_base_b),
    .i_trig     (trig_b),
    .o_hit      (hit_b),
    .o_cmd_set  (cset_b),
    .o_cmd_clr  (cclr_b),
    .o_cnt      (cnt_b)
  );

  // circuit A owns the low half, B the high half
  assign hit_vec     = {hit_b, hit_a};
  assign cmd_set_vec = {cset_b, cset_a};
  assign cmd_clr_vec = {cclr_b, cclr_a};
  assign line_style  = {{4{scan_b_style_r}}, {4{scan_a_style_r}}};

  // level that keeps a line up: scan input for scan-set lines
  always_comb
  begin
    for (int n = 0; n < CH; n++)
    begin
      if (!scan_src_r[n])
        src_lvl[n] = req[n];
      else if (n < 4)
        src_lvl[n] = src_a_lvl;
      else
        src_lvl[n] = src_b_lvl;
    end
  end

  // own inputs other than inputs 0 and 4 set their own line
  assign set_vec = hit_vec | cmd_set_vec
                 | (req_rise & dsr_pkg::DSR_OWN_SET_MASK);

  // withdrawal only counts with style clear; style set waits for service
  assign withdraw = ~line_style & ~cmd_hold_r & ~src_lvl;
  // I/O requesters drop as soon as the controller starts on them
  assign serviced = i_xfer_start & (io_mapped_r | line_style);

  // style set with memory mapping is illegal; it behaves as I/O mapped
  assign clr_vec = withdraw | serviced | cmd_clr_vec;

  // a new set wins over a clear in the same cycle
  assign latch_nxt = set_vec | (latch_r & ~clr_vec);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      latch_r <= '0;
    else
      latch_r <= latch_nxt;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      scan_src_r <= '0;
    else
      scan_src_r <= (scan_src_r & ~set_vec) | hit_vec;
  end

  // software-set lines ignore input withdrawal
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      cmd_hold_r <= '0;
    else
      cmd_hold_r <= (cmd_hold_r & ~set_vec & ~clr_vec) | cmd_set_vec;
  end

  // bypassed channels skip the scan logic entirely
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_ctrl_request_out <= '0;
    else
      o_ctrl_request_out <= (bypass_r & req)
                          | (~bypass_r & latch_r);
  end

  // limit holds a parameter, not a wrap value, while a command is up
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_bus_lock <= 1'b0;
    else
      o_bus_lock <= (cmd_r != dsr_pkg::DSR_CMD_RUN);
  end

endmodule

`default_nettype wire

// >>> design/dsr_scan.sv
`timescale 1ns/100ps
`default_nettype none

module dsr_scan
#(
  parameter logic [2:0] CH_BASE = 3'h0
)
(
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // settings
  input  wire logic [1:0] i_cmd,
  input  wire logic       i_style,
  input  wire logic [2:0] i_wrap,
  input  wire logic [2:0] i_cnt_base,
  // scan input rising edge
  input  wire logic       i_trig,
  // line actions for this cycle
  output logic      [3:0] o_hit,
  output logic      [3:0] o_cmd_set,
  output logic      [3:0] o_cmd_clr,
  // counter
  output var  logic [2:0] o_cnt
);

  logic       run;
  logic       own_idx;
  logic [2:0] idx;

  assign run     = (i_cmd == dsr_pkg::DSR_CMD_RUN);
  assign own_idx = (i_wrap[2] == CH_BASE[2]);

  always_comb
  begin
    idx = 3'h0;
    o_hit = 4'h0;
    o_cmd_set = 4'h0;
    o_cmd_clr = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      idx = 3'(i) + i_cnt_base;
      if (run && i_trig)
      begin
        if (i_style)
          o_hit[i] = (3'(i) <= i_wrap);
        else
          o_hit[i] = (o_cnt == idx);
      end
      // limit field carries a line number here
      if (own_idx && (i_wrap[1:0] == 2'(i)))
      begin
        o_cmd_set[i] = (i_cmd == dsr_pkg::DSR_CMD_SET);
        o_cmd_clr[i] = (i_cmd == dsr_pkg::DSR_CMD_CLR);
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_cnt <= 3'h0;
    else if ((i_cmd == dsr_pkg::DSR_CMD_CNT_CLR) && (i_wrap == 3'h0))
      o_cnt <= 3'h0;
    else if (run && i_trig && !i_style)
      o_cnt <= (o_cnt >= i_wrap) ? 3'h0 : o_cnt + 3'h1;
  end

endmodule

`default_nettype wire

// >>> design/dsr_sync3.sv
`timescale 1ns/100ps
`default_nettype none

module dsr_sync3
#(
  parameter int         W       = 8,
  parameter logic [7:0] RST_VAL = 8'hff
)
(
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_sys_rst,
  // asynchronous level in, filtered level out
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_level
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      s1_r <= RST_VAL[W-1:0];
      s2_r <= RST_VAL[W-1:0];
      s3_r <= RST_VAL[W-1:0];
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      o_level <= RST_VAL[W-1:0];
    else
      o_level <= (s2_r & ~(s2_r ^ s3_r)) | (o_level & (s2_r ^ s3_r));
  end

endmodule

`default_nettype wire
